// ---- bench/spl_sva.sv ----
/*
  Checker for the load link and the device's pump, lock and monitor pins.
  Assumes the bench instantiates it beside the link, host HALF_CYC of 4.
*/
`timescale 1ns/10ps
`default_nettype none

module spl_sva
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic ls_out,
  input wire logic load_strobe,
  input wire logic phase_polarity_sel,
  input wire logic charge_pump_o,
  input wire logic charge_pump_oe_o,
  input wire logic ext_pump_r_o,
  input wire logic ext_pump_p_o,
  input wire logic ext_pump_p_oe_o,
  input wire logic fast_lock_switch_out_oe_o,
  input wire logic lock_detect_out_o,
  input wire logic compare_monitor_out_o,
  input wire logic ref_divided_o,
  input wire logic vco_divided_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Data must sit still around each serial clock rise
  property p_sdata_hold; $rose(sclk) |-> $stable(sdata)[*4]; endproperty
  a_sdata_hold: assert property (p_sdata_hold) else $error("data moved");
  // No load while bits are still arriving
  property p_no_early_load; $rose(sclk) |-> !ls_out; endproperty
  a_no_early_load: assert property (p_no_early_load) else $error("early load");
  // Switch floats once the strobe pin has been low for six cycles
  property p_flsw; (!load_strobe)[*6] |-> !fast_lock_switch_out_oe_o; endproperty
  a_flsw: assert property (p_flsw) else $error("switch on");
  // Open drain never drives high
  property p_drain; ext_pump_p_oe_o |-> !ext_pump_p_o; endproperty
  a_drain: assert property (p_drain) else $error("pump p high");
  // External pins track the pump sense in either polarity
  property p_pump_p; ext_pump_p_oe_o == (charge_pump_oe_o && charge_pump_o); endproperty
  a_pump_p: assert property (p_pump_p) else $error("pump p sense");
  property p_pump_r; ext_pump_r_o == (charge_pump_oe_o && !charge_pump_o); endproperty
  a_pump_r: assert property (p_pump_r) else $error("pump r sense");
  // Lock is low exactly while a phase error drives the pump
  property p_lock; lock_detect_out_o == !charge_pump_oe_o; endproperty
  a_lock: assert property (p_lock) else $error("lock wrong");
  // Monitor follows the divider that polarity selects
  property p_mon_ref;
    (phase_polarity_sel[*8] ##0 ref_divided_o) |-> ##[0:1] compare_monitor_out_o;
  endproperty
  a_mon_ref: assert property (p_mon_ref) else $error("monitor ref");
  property p_mon_vco;
    ((!phase_polarity_sel)[*8] ##0 vco_divided_o) |-> ##[0:1] compare_monitor_out_o;
  endproperty
  a_mon_vco: assert property (p_mon_vco) else $error("monitor vco");
  // A lone reference pulse drives the pump high, low when reversed
  property p_pump_dir;
    ($stable(phase_polarity_sel)[*8] ##0 (ref_divided_o && !vco_divided_o && lock_detect_out_o))
      |=> charge_pump_oe_o && (charge_pump_o == $past(phase_polarity_sel));
  endproperty
  a_pump_dir: assert property (p_pump_dir) else $error("pump sense");
endmodule

`default_nettype wire

// ---- bench/tb.sv ----
/*
  Bench: host and device joined by the link, driven over Wishbone.
  Assumes short host timing (HALF_CYC 4, LOAD_CYC 8) and a 250 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none

module tb;
  import spl_pkg::*;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        wb_cyc  = 1'b0;
  logic        wb_stb  = 1'b0;
  logic        wb_we   = 1'b0;
  logic [3:0]  wb_adr  = 4'h0;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        xtal    = 1'b0;
  logic        pre     = 1'b0;
  logic        sclk_d  = 1'b0;
  logic [18:0] cap     = 19'h0;
  logic [31:0] rd_v;
  logic [31:0] ctrl_v  = 32'h4;
  logic        xo, cp, cp_oe, epr, epp, epp_oe, fl, fl_oe, lock, mon, refd, vcod;
  int          ph      = 0;
  int          xt_cnt  = 0;
  int          pr_cnt  = 0;
  int          ncap    = 0;
  int          failures = 0;
  int          compares = 0;
  int          seed;

  always #2 clk_i = ~clk_i;

  spl_if lk();
  spl_host #(.HALF_CYC(4), .LOAD_CYC(8)) i_spl_host (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(lk));
  spl_device i_spl_device (.clk_i(clk_i), .rst_i(rst_i), .link(lk), .xtal_in_i(xtal),
    .prescaler_in_i(pre), .xtal_out_o(xo), .charge_pump_o(cp), .charge_pump_oe_o(cp_oe),
    .ext_pump_r_o(epr), .ext_pump_p_o(epp), .ext_pump_p_oe_o(epp_oe),
    .fast_lock_switch_out_o(fl), .fast_lock_switch_out_oe_o(fl_oe),
    .lock_detect_out_o(lock), .compare_monitor_out_o(mon), .ref_divided_o(refd),
    .vco_divided_o(vcod));
  spl_sva i_spl_sva (.clk_i(clk_i), .rst_i(rst_i), .sclk(lk.sclk), .sdata(lk.sdata),
    .ls_out(lk.ls_out), .load_strobe(lk.load_strobe),
    .phase_polarity_sel(lk.phase_polarity_sel), .charge_pump_o(cp), .charge_pump_oe_o(cp_oe),
    .ext_pump_r_o(epr), .ext_pump_p_o(epp), .ext_pump_p_oe_o(epp_oe),
    .fast_lock_switch_out_oe_o(fl_oe), .lock_detect_out_o(lock), .compare_monitor_out_o(mon),
    .ref_divided_o(refd), .vco_divided_o(vcod));

  // Crystal period 6 cycles, prescaler 4; the bench counts its own rises
  always @(posedge clk_i)
  begin
    ph <= (ph == 5) ? 0 : ph + 1;
    if (ph == 2 || ph == 5) xtal <= ~xtal;
    if ((ph == 2 || ph == 5) && !xtal) xt_cnt <= xt_cnt + 1;
    if (ph % 2 == 1) pre <= ~pre;
    if (ph % 2 == 1 && !pre) pr_cnt <= pr_cnt + 1;
  end

  // Wire watcher: collects the bit seen at every serial clock rise
  always @(posedge clk_i)
  begin
    sclk_d <= lk.sclk;
    if (lk.sclk && !sclk_d)
    begin
      cap  <= {cap[17:0], lk.sdata};
      ncap <= ncap + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // A wait ran out: count it and close the run
  task automatic hang();
    failures++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    print_verdict();
  endtask

  // Classic single Wishbone cycle; read data lands in rd_v
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (wb_ack === 1'b1) break;
    end
    if (i == 20) hang();
    rd_v = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  function automatic logic [18:0] ref_word(input logic [13:0] r, input logic sw);
    return {3'h0, r, sw, 1'b1};
  endfunction

  function automatic logic [18:0] div_word(input logic [10:0] n, input logic [6:0] a);
    return {n, a, 1'b0};
  endfunction

  // Ship one word and compare what crossed the wire
  task automatic send(input logic [18:0] w, input logic [4:0] len);
    int i;
    logic [31:0] m;
    m = (32'h1 << len) - 32'h1;
    wb(1'b1, 4'h8, {27'h0, len});
    wb(1'b1, 4'h4, {13'h0, w});
    ncap = 0;
    wb(1'b1, 4'h0, ctrl_v | 32'h1);
    for (i = 0; i < 400; i++)
    begin
      wb(1'b0, 4'hC, 32'h0);
      if (rd_v[0] === 1'b0) break;
    end
    if (i == 400) hang();
    chk(ncap, len);
    chk({13'h0, cap} & m, {13'h0, w} & m);
  endtask

  // Rises of the divider's input between two steady output pulses
  task automatic meas(input logic v, output int d);
    int i;
    int k;
    int t0;
    k = 0;
    t0 = 0;
    d = 0;
    for (i = 0; i < 40000 && k < 2; i++)
    begin
      @(posedge clk_i);
      #1;
      if ((v ? vcod : refd) === 1'b1)
      begin
        k++;
        if (k == 1) t0 = v ? pr_cnt : xt_cnt;
        if (k == 2) d = (v ? pr_cnt : xt_cnt) - t0;
      end
    end
    if (k < 2) hang();
  endtask

  // Main sequence: registers, both moduli, polarity, released strobe
  initial
  begin
    int r, n, a, d;
    logic sw;
    seed = $urandom(99291);
    n = 16;
    a = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0);
    chk(rd_v, 32'h4);
    wb(1'b0, 4'h8, 32'h0);
    chk(rd_v, 32'h13);
    wb(1'b0, 4'h2, 32'h0);
    chk(rd_v, 32'h0);
    $display("test registers done");
    for (int k = 0; k < 2; k++)
    begin
      sw = (k == 0);
      r = (k == 0) ? 8 : 8 + $urandom % 33;
      send(ref_word(r[13:0], sw), 5'h10);
      meas(1'b0, d);
      chk(d, r);
      meas(1'b1, d);
      chk(d, (sw ? 64 : 128) * n + a);
      n = 16 + $urandom % 5;
      a = (k == 0) ? n - 1 : 0;
      send(div_word(n[10:0], a[6:0]), 5'h13);
      meas(1'b1, d);
      chk(d, (sw ? 64 : 128) * n + a);
      $display("test modulus %0d done", k);
    end
    // Polarity driven low, then left to the pull-up
    ctrl_v = 32'h2;
    wb(1'b1, 4'h0, ctrl_v);
    meas(1'b1, d);
    chk(lk.phase_polarity_sel, 1'b0);
    chk(d, 128 * n + a);
    ctrl_v = 32'h0;
    wb(1'b1, 4'h0, ctrl_v);
    @(posedge clk_i);
    #1;
    chk(lk.phase_polarity_sel, 1'b1);
    $display("test polarity done");
    // Strobe released: pull-up keeps the latches loading
    ctrl_v = 32'h8;
    wb(1'b1, 4'h0, ctrl_v);
    @(posedge clk_i);
    #1;
    chk(lk.load_strobe, 1'b1);
    r = 8 + $urandom % 33;
    send(ref_word(r[13:0], 1'b1), 5'h10);
    meas(1'b0, d);
    chk(d, r);
    $display("test released strobe done");
    print_verdict();
  end
endmodule

`default_nettype wire

// ---- core/spl_device.sv ----
/*
  Digital core of the serially programmed PLL synthesizer: shift
  registers, latches, reference and main dividers, phase comparator,
  polarity control, lock detect and fast-lock switch gating.
  Assumes all pins, including the crystal and prescaler inputs, are
  sampled by clk_i, which must run well above twice their rates.
*/
// The Wishbone interface to the registers and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "spl_regs.svh"

// How it works
// RULE1 - Each serial clock rise shifts data in
// RULE2 - Last bit picks the target latch
// RULE3 - Strobe high, bit high: load reference latch
// RULE4 - Strobe high, bit low: load divider latch
// RULE5 - Floating strobe reads high, loads happen
// RULE6 - Fast-lock pin carries pump only under strobe
// RULE7 - Polarity low reverses all pump outputs
// RULE8 - Floating polarity pin reads high, normal
// RULE9 - Monitor shows reference or VCO divider output
// RULE10 - Lock output high, low during phase error
// RULE11 - External P pump only pulls low
// RULE12 - Reference: 16-bit shift, 15-bit latch, 14-bit counter
// RULE13 - Host keeps reference ratio 8 to 16383
// RULE14 - Reference count is plain binary field
// RULE15 - Prescaler select high 64/65, low 128/129
// RULE16 - Host sets target bit high for reference
// RULE17 - Host sends MSB first, target bit last
// RULE18 - Divider: 19-bit shift, 18-bit latch, 7+11 counters
// RULE19 - A in bits 1-7, N in 8-18
// RULE20 - Loop divides by P times N plus A
// RULE21 - Pump high on reference lead, low on lag
// RULE22 - Prescaler select sits just before target bit
// RULE23 - Latches hold while strobe is low
// RULE24 - Swallow holds higher modulus for A counts
module spl_device
  import spl_pkg::*;
#(
  parameter int REF_SR_W = `SPL_REF_SR_W,
  parameter int DIV_SR_W = `SPL_DIV_SR_W
)
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  spl_if.dev        link,
  input  wire logic xtal_in_i,
  input  wire logic prescaler_in_i,
  output logic      xtal_out_o,
  output logic      charge_pump_o,
  output logic      charge_pump_oe_o,
  output logic      ext_pump_r_o,
  output logic      ext_pump_p_o,
  output logic      ext_pump_p_oe_o,
  output logic      fast_lock_switch_out_o,
  output logic      fast_lock_switch_out_oe_o,
  output logic      lock_detect_out_o,
  output logic      compare_monitor_out_o,
  output logic      ref_divided_o,
  output logic      vco_divided_o
);
  logic [5:0]                    sync_q;
  logic                          sclk_s;
  logic                          data_s;
  logic                          ls_s;
  logic                          fc_s;
  logic                          xtal_s;
  logic                          fin_s;
  logic                          sclk_d_r;
  logic                          xtal_d_r;
  logic                          fin_d_r;
  logic [REF_SR_W-1:0]           ref_sr_r;
  logic [DIV_SR_W-1:0]           div_sr_r;
  logic [`SPL_REF_LATCH_W-1:0]   ref_latch_r;
  logic [`SPL_DIV_LATCH_W-1:0]   div_latch_r;
  logic [`SPL_REF_CNT_W-1:0]     ref_cnt_r;
  logic [`SPL_PRE_W-1:0]         pre_cnt_r;
  logic [`SPL_SWAL_W-1:0]        a_cnt_r;
  logic [`SPL_PROG_W-1:0]        n_cnt_r;
  logic                          ref_p_r;
  logic                          vco_p_r;
  logic                          up_r;
  logic                          dn_r;

  // All pins cross into clk_i before any logic looks at them
  spl_sync #(
    .W (6)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({link.sclk, link.sdata, link.load_strobe, link.phase_polarity_sel,
             xtal_in_i, prescaler_in_i}),
    .q_o   (sync_q)
  );

  assign {sclk_s, data_s, ls_s, fc_s, xtal_s, fin_s} = sync_q;

  // Edge finders on the synchronised clocks
  logic sclk_rise;
  logic xtal_rise;
  logic fin_rise;
  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign xtal_rise = xtal_s & ~xtal_d_r;
  assign fin_rise  = fin_s & ~fin_d_r;

  // Latch field decode
  logic [`SPL_REF_CNT_W-1:0] r_val;
  logic                      ratio_sel;
  logic [`SPL_SWAL_W-1:0]    a_val;
  logic [`SPL_PROG_W-1:0]    n_val;
  assign r_val     = ref_latch_r[`SPL_RL_CNT_MSB:`SPL_RL_CNT_LSB];  // RULE14
  assign ratio_sel = ref_latch_r[`SPL_RL_SW];                      // RULE22
  assign a_val     = div_latch_r[`SPL_DL_A_MSB:`SPL_DL_A_LSB];      // RULE19
  assign n_val     = div_latch_r[`SPL_DL_N_MSB:`SPL_DL_N_LSB];      // RULE19

  // Load decode: strobe level plus the target bit last shifted in
  logic target_bit;
  logic load_ref;
  logic load_div;
  assign target_bit = ref_sr_r[`SPL_TARGET_BIT];                   // RULE2
  assign load_ref   = ls_s & target_bit;                           // RULE3
  assign load_div   = ls_s & ~target_bit;                          // RULE4

  // Edge history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_d_r <= 1'b0;
      xtal_d_r <= 1'b0;
      fin_d_r  <= 1'b0;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      xtal_d_r <= xtal_s;
      fin_d_r  <= fin_s;
    end
  end

  // Both shift registers take the same bit; data was synced with the clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_sr_r <= '0;
      div_sr_r <= '0;
    end
    else if (sclk_rise)
    begin
      ref_sr_r <= {ref_sr_r[REF_SR_W-2:0], data_s};                // RULE1 RULE12
      div_sr_r <= {div_sr_r[DIV_SR_W-2:0], data_s};                // RULE1 RULE18
    end
  end

  // Latches change only under strobe, so shifting with the strobe low never disturbs ratios
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_latch_r <= `SPL_REF_LATCH_RST;
      div_latch_r <= `SPL_DIV_LATCH_RST;
    end
    else
    begin
      if (load_ref)
        ref_latch_r <= ref_sr_r[REF_SR_W-1:1];                     // RULE3 RULE12
      if (load_div)
        div_latch_r <= div_sr_r[DIV_SR_W-1:1];                     // RULE4 RULE18
    end                                                            // RULE23
  end

  // Reference divider: counts R crystal edges per output pulse
  logic ref_tc;
  assign ref_tc = (ref_cnt_r <= `SPL_REF_CNT_W'(1));

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ref_cnt_r <= '0;
      ref_p_r   <= 1'b0;
    end
    else
    begin
      ref_p_r <= xtal_rise & ref_tc;
      if (xtal_rise)
        ref_cnt_r <= ref_tc ? r_val : ref_cnt_r - `SPL_REF_CNT_W'(1);  // RULE12
    end
  end

  // Main divider: prescaler, swallow and programmable counters
  logic [`SPL_PRE_W-1:0]  p_base;
  logic [`SPL_PRE_W-1:0]  p_mod;
  logic                   pre_tc;
  logic                   pre_end;
  logic                   n_tc;
  logic [`SPL_SWAL_W-1:0] a_nxt;
  assign p_base  = ratio_sel ? `SPL_P_SMALL : `SPL_P_LARGE;        // RULE15
  assign pre_tc  = (pre_cnt_r <= `SPL_PRE_W'(1));
  assign pre_end = fin_rise & pre_tc;
  assign n_tc    = (n_cnt_r <= `SPL_PROG_W'(1));
  // Next swallow count decides the modulus of the coming prescaler cycle
  assign a_nxt   = n_tc ? a_val :
                   (a_cnt_r != '0) ? a_cnt_r - `SPL_SWAL_W'(1) : a_cnt_r;
  assign p_mod   = (a_nxt != '0) ? p_base + `SPL_PRE_W'(1) : p_base;  // RULE24

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pre_cnt_r <= '0;
      a_cnt_r   <= '0;
      n_cnt_r   <= '0;
      vco_p_r   <= 1'b0;
    end
    else
    begin
      vco_p_r <= pre_end & n_tc;                                   // RULE20
      if (fin_rise)
        pre_cnt_r <= pre_tc ? p_mod : pre_cnt_r - `SPL_PRE_W'(1);
      if (pre_end)
      begin
        a_cnt_r <= a_nxt;                                          // RULE24
        n_cnt_r <= n_tc ? n_val : n_cnt_r - `SPL_PROG_W'(1);       // RULE20
      end
    end
  end

  // Phase comparator: whichever pulse comes first holds until the other
  logic up_nxt;
  logic dn_nxt;
  logic both;
  assign both   = (up_r | ref_p_r) & (dn_r | vco_p_r);
  assign up_nxt = (up_r | ref_p_r) & ~both;
  assign dn_nxt = (dn_r | vco_p_r) & ~both;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      up_r <= 1'b0;
      dn_r <= 1'b0;
    end
    else
    begin
      up_r <= up_nxt;
      dn_r <= dn_nxt;
    end
  end

  // Output stage; up and dn are never both set, so oe is simply their or
  logic cp_val;
  logic cp_en;
  assign cp_val = fc_s ? up_r : dn_r;                              // RULE21 RULE7
  assign cp_en  = up_r | dn_r;                                     // RULE21

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      charge_pump_o             <= 1'b0;
      charge_pump_oe_o          <= 1'b0;
      ext_pump_r_o              <= 1'b0;
      ext_pump_p_oe_o           <= 1'b0;
      fast_lock_switch_out_o    <= 1'b0;
      fast_lock_switch_out_oe_o <= 1'b0;
      lock_detect_out_o         <= 1'b1;
      compare_monitor_out_o     <= 1'b0;
      ref_divided_o             <= 1'b0;
      vco_divided_o             <= 1'b0;
      xtal_out_o                <= 1'b1;
    end
    else
    begin
      charge_pump_o             <= cp_val;
      charge_pump_oe_o          <= cp_en;
      ext_pump_r_o              <= fc_s ? dn_r : up_r;             // RULE7
      ext_pump_p_oe_o           <= fc_s ? up_r : dn_r;             // RULE7 RULE11
      fast_lock_switch_out_o    <= cp_val;                         // RULE6
      fast_lock_switch_out_oe_o <= ls_s & cp_en;                   // RULE6
      lock_detect_out_o         <= ~(up_r | dn_r);                 // RULE10
      compare_monitor_out_o     <= fc_s ? ref_p_r : vco_p_r;       // RULE9
      ref_divided_o             <= ref_p_r;
      vco_divided_o             <= vco_p_r;
      xtal_out_o                <= ~xtal_s;
    end
  end

  // Open drain: the P pump output level is always low
  assign ext_pump_p_o = 1'b0;                                      // RULE11
endmodule

`default_nettype wire

// ---- core/spl_host.sv ----
/*
  Host end: a classic Wishbone slave that holds a word and shifts it out
  on the three-wire link MSB first, then raises the load strobe.
  Assumes software writes a valid word with the right target bit.
*/
`timescale 1ns/10ps
`default_nettype none
`include "spl_regs.svh"

module spl_host
  import spl_pkg::*;
#(
  parameter int HALF_CYC = `SPL_SCLK_HALF_CYC,
  parameter int LOAD_CYC = `SPL_LOAD_CYC
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  spl_if.host              link
);
  spl_host_state_t state_r;
  logic [18:0]     word_r;
  logic [4:0]      len_r;
  logic [4:0]      idx_r;
  logic [7:0]      tmr_r;
  logic            fc_oe_r;
  logic            fc_lvl_r;
  logic            float_r;
  logic            sclk_r;
  logic            sdata_r;
  logic            ls_r;
  logic            ack_r;
  logic [31:0]     rdat_r;

  // Bus decode; a write takes effect at the edge where ack is seen high
  logic req;
  logic wr_fire;
  logic sel_ctrl;
  logic sel_data;
  logic sel_len;
  logic sel_stat;
  logic busy;
  logic start;
  logic tmr_done;
  assign req      = wb_cyc_i & wb_stb_i;
  assign wr_fire  = req & wb_we_i & ack_r;
  assign sel_ctrl = (wb_adr_i == `SPL_HOST_CTRL);
  assign sel_data = (wb_adr_i == `SPL_HOST_DATA);
  assign sel_len  = (wb_adr_i == `SPL_HOST_LEN);
  assign sel_stat = (wb_adr_i == `SPL_HOST_STATUS);
  assign busy     = (state_r != SPL_IDLE);
  // A start while busy is dropped
  assign start    = wr_fire & sel_ctrl & wb_sel_i[0] & wb_dat_i[`SPL_CTRL_START] & ~busy;
  assign tmr_done = (tmr_r == 8'h00);

  // Read mux; unmapped addresses read zero
  logic [31:0] rd_mux;
  assign rd_mux = sel_ctrl ? {28'h0000000, float_r, fc_lvl_r, fc_oe_r, 1'b0} :
                  sel_data ? {13'h0000, word_r} :
                  sel_len  ? {27'h0000000, len_r} :
                  sel_stat ? {31'h00000000, busy} : 32'h00000000;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end
    else
    begin
      ack_r  <= req & ~ack_r;
      rdat_r <= rd_mux;
    end
  end

  // Software registers with byte lanes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      word_r   <= 19'h00000;
      len_r    <= `SPL_LEN_RST;
      fc_oe_r  <= 1'b0;
      fc_lvl_r <= 1'b1;
      float_r  <= 1'b0;
    end
    else if (wr_fire)
    begin
      if (sel_ctrl & wb_sel_i[0])
      begin
        fc_oe_r  <= wb_dat_i[`SPL_CTRL_FC_OE];
        fc_lvl_r <= wb_dat_i[`SPL_CTRL_FC_LVL];
        float_r  <= wb_dat_i[`SPL_CTRL_FLOAT];
      end
      if (sel_data & wb_sel_i[0])
        word_r[7:0] <= wb_dat_i[7:0];
      if (sel_data & wb_sel_i[1])
        word_r[15:8] <= wb_dat_i[15:8];
      if (sel_data & wb_sel_i[2])
        word_r[18:16] <= wb_dat_i[18:16];
      if (sel_len & wb_sel_i[0] & ~busy)
        len_r <= wb_dat_i[4:0];
    end
  end

  // Serial engine: data is set up a half period before each rising edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= SPL_IDLE;
      idx_r   <= 5'h00;
      tmr_r   <= 8'h00;
      sclk_r  <= 1'b0;
      sdata_r <= 1'b0;
      ls_r    <= 1'b0;
    end
    else
    begin
      case (state_r)
        SPL_IDLE:
        begin
          ls_r <= 1'b0;
          if (start)
          begin
            state_r <= SPL_LOW;
            idx_r   <= len_r - 5'h01;
            sdata_r <= word_r[len_r - 5'h01];                      // RULE17
            tmr_r   <= 8'(HALF_CYC - 1);
          end
        end
        SPL_LOW:
        begin
          tmr_r <= tmr_r - 8'h01;
          if (tmr_done)
          begin
            sclk_r  <= 1'b1;                                       // RULE1
            tmr_r   <= 8'(HALF_CYC - 1);
            state_r <= SPL_HIGH;
          end
        end
        SPL_HIGH:
        begin
          tmr_r <= tmr_r - 8'h01;
          if (tmr_done)
          begin
            sclk_r <= 1'b0;
            if (idx_r == 5'h00)
            begin
              tmr_r   <= 8'(LOAD_CYC - 1);                         // RULE2
              ls_r    <= 1'b1;
              state_r <= SPL_LOAD;
            end
            else
            begin
              idx_r   <= idx_r - 5'h01;
              sdata_r <= word_r[idx_r - 5'h01];                    // RULE17
              tmr_r   <= 8'(HALF_CYC - 1);
              state_r <= SPL_LOW;
            end
          end
        end
        SPL_LOAD:
        begin
          tmr_r <= tmr_r - 8'h01;
          if (tmr_done)
          begin
            ls_r    <= 1'b0;
            state_r <= SPL_IDLE;
          end
        end
        default:
          state_r <= SPL_IDLE;
      endcase
    end
  end

  assign wb_ack_o    = ack_r;
  assign wb_dat_o    = rdat_r;
  assign link.sclk   = sclk_r;
  assign link.sdata  = sdata_r;
  assign link.ls_out = ls_r;
  assign link.ls_oe  = ~float_r;
  assign link.fc_out = fc_lvl_r;
  assign link.fc_oe  = fc_oe_r;
endmodule

`default_nettype wire

// ---- core/spl_if.sv ----
/*
  Three-wire load link plus the polarity select pin.
  Assumes the host drives clock and data always; strobe and polarity
  are two-way pins with a pull-up, resolved here from the enables.
*/
`timescale 1ns/10ps
`default_nettype none

interface spl_if;
  logic sclk;
  logic sdata;
  logic ls_out;
  logic ls_oe;
  logic fc_out;
  logic fc_oe;
  logic load_strobe;
  logic phase_polarity_sel;

  // Pull-ups: an undriven pin reads high
  assign load_strobe        = ls_oe ? ls_out : 1'b1;  // RULE5
  assign phase_polarity_sel = fc_oe ? fc_out : 1'b1;  // RULE8

  modport host (output sclk, output sdata, output ls_out, output ls_oe,
                output fc_out, output fc_oe);
  modport dev  (input sclk, input sdata, input load_strobe, input phase_polarity_sel);
endinterface

`default_nettype wire

// ---- core/spl_pkg.sv ----
/*
  Types for the serial PLL divider load block.
  Assumes the constants header is on the include path.
*/
package spl_pkg;
  // Host serial engine states
  typedef enum logic [1:0]
  {
    SPL_IDLE = 2'b00,
    SPL_LOW  = 2'b01,
    SPL_HIGH = 2'b10,
    SPL_LOAD = 2'b11
  } spl_host_state_t;
endpackage

// ---- core/spl_regs.svh ----
/*
  Constants for the serial PLL divider load block: word layout, latch
  fields, reset values, prescaler moduli, host register map and timing.
  Assumes it is included by bare name from every file that needs it.
*/
`ifndef SPL_REGS_SVH
`define SPL_REGS_SVH

// Shift register, latch and counter widths
`define SPL_REF_SR_W     16
`define SPL_DIV_SR_W     19
`define SPL_REF_LATCH_W  15
`define SPL_DIV_LATCH_W  18
`define SPL_REF_CNT_W    14
`define SPL_SWAL_W       7
`define SPL_PROG_W       11
`define SPL_PRE_W        8

// Last bit of a word is the target bit, at shift register bit 0
`define SPL_TARGET_BIT   0

// Reference latch fields
`define SPL_RL_SW        0
`define SPL_RL_CNT_LSB   1
`define SPL_RL_CNT_MSB   14

// Divider latch fields
`define SPL_DL_A_LSB     0
`define SPL_DL_A_MSB     6
`define SPL_DL_N_LSB     7
`define SPL_DL_N_MSB     17

// Latch reset values: R = 8 with 64/65, N = 16 with A = 0
`define SPL_REF_LATCH_RST 15'h0011
`define SPL_DIV_LATCH_RST 18'h00800

// Prescaler base moduli
`define SPL_P_SMALL      8'h40
`define SPL_P_LARGE      8'h80

// Host register byte offsets
`define SPL_HOST_CTRL    4'h0
`define SPL_HOST_DATA    4'h4
`define SPL_HOST_LEN     4'h8
`define SPL_HOST_STATUS  4'hC

// Host control bits
`define SPL_CTRL_START   0
`define SPL_CTRL_FC_OE   1
`define SPL_CTRL_FC_LVL  2
`define SPL_CTRL_FLOAT   3
`define SPL_STAT_BUSY    0
`define SPL_LEN_RST      5'h13

// Timing: serial clock period and system clock period in ns
`define SPL_SCLK_PERIOD_NS 160
`define SPL_CLK_PERIOD_NS  4
`define SPL_SCLK_HALF_CYC  ((`SPL_SCLK_PERIOD_NS / `SPL_CLK_PERIOD_NS) / 2)
`define SPL_LOAD_CYC       (2 * `SPL_SCLK_HALF_CYC)

`endif

// ---- core/spl_sync.sv ----
/*
  Two-flop synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level or a clock well below clk_i / 2.
*/
`timescale 1ns/10ps
`default_nettype none

module spl_sync
  import spl_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;
endmodule

`default_nettype wire
